/* include/fieldbus_status_cfg.svh */
// Timing, field and address capture constants for the fieldbus slave status and address block.
`ifndef FIELDBUS_STATUS_CFG_SVH
`define FIELDBUS_STATUS_CFG_SVH
// ==========================================================
// Clock and lamp timing
`define FB_CLK_MHZ 40
`define FB_TICK_MS 50
`define FB_TICK_W 32
`define FB_PHASE_W 5
`define FB_BLINK_BIT 2
`define FB_FLASH_LEN 5'h04
`define FB_FLASH2_ON 5'h08
`define FB_FLASH2_OFF 5'h0C
// ==========================================================
// Station address capture
`define FB_CAPTURE_WAIT 4'h8
`define FB_DIGIT_MAX 4'h9
`define FB_TENS_MUL 7'h0A
`define FB_ADDR_W 16
`define FB_BCD_W 7
`endif

/* include/fb_status_pkg.sv */
// Types shared by the fieldbus slave status and address block.
`default_nettype none
package fb_status_pkg;
  // Slave state as reported by the protocol engine.
  typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} slave_state_t;
  // Lamp display pattern.
  typedef enum logic [2:0] {LAMP_OFF, LAMP_ON, LAMP_BLINK, LAMP_FLASH1, LAMP_FLASH2} lamp_mode_t;
endpackage : fb_status_pkg
`default_nettype wire

/* rtl/fieldbus_slave_status_and_address.sv */
// Status lamps, station address capture and data hand-off for a fieldbus slave option board.
// Contract
// R1 - Link lamp: dark, steady, flicker on traffic.
// R2 - Run lamp shows slave state pattern.
// R3 - Error lamp: dark, blink, double flash.
// R4 - Address is tens switch times ten plus ones.
// R5 - Switch address sampled once after power-on.
// R6 - Switch address used only in fixed mode.
// R7 - Other modes: master assigns the address.
// R8 - Cyclic command out, status returned in.
// R9 - Acyclic parameter writes, apart from cyclic data.
// R10 - Serial register protocol path stays disabled.
// R11 - Slave status offered for master monitoring.
// R12 - Free-running divider times all lamp patterns.
`include "fieldbus_status_cfg.svh"
`default_nettype none
module fieldbus_slave_status_and_address
  import fb_status_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `FB_TICK_MS * 1000 * `FB_CLK_MHZ,
  parameter int DATA_W = 16
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic LINK_UP_IN,
  input wire logic LINK_ACT_IN,
  input wire logic LINK_UP_OUT,
  input wire logic LINK_ACT_OUT,
  input wire logic [3:0] SW_TENS,
  input wire logic [3:0] SW_ONES,
  input wire logic [1:0] SLAVE_STATE,
  input wire logic CFG_ERR,
  input wire logic COMM_ERR,
  input wire logic ADDR_MODE_FIXED,
  input wire logic [`FB_ADDR_W-1:0] ASSIGNED_ADDR,
  input wire logic CYC_OUT_VALID,
  input wire logic [DATA_W-1:0] CYC_CMD,
  input wire logic [DATA_W-1:0] CYC_TARGET,
  input wire logic [DATA_W-1:0] DRV_STATUS,
  input wire logic [DATA_W-1:0] DRV_ACTUAL,
  input wire logic PARAM_REQ,
  input wire logic [DATA_W-1:0] PARAM_INDEX,
  input wire logic [DATA_W-1:0] PARAM_DATA,
  output logic LED_LINK_IN,
  output logic LED_LINK_OUT,
  output logic LED_RUN,
  output logic LED_ERR,
  output logic [`FB_ADDR_W-1:0] STATION_ADDR,
  output logic ADDR_CAPTURED,
  output logic [DATA_W-1:0] DRV_CMD,
  output logic [DATA_W-1:0] DRV_TARGET,
  output logic CYC_IN_VALID,
  output logic [DATA_W-1:0] CYC_STATUS,
  output logic [DATA_W-1:0] CYC_ACTUAL,
  output logic PARAM_WE,
  output logic [DATA_W-1:0] PARAM_ADDR,
  output logic [DATA_W-1:0] PARAM_WDATA,
  output logic [3:0] SLAVE_STATUS,
  output logic MODBUS_EN
);
  localparam int SYNC_W = 12;
  localparam logic [`FB_TICK_W-1:0] TICK_LAST = `FB_TICK_W'(TICK_CYCLES - 1);
  // Clamps a switch digit to the decimal range.
  function automatic logic [3:0] digit_clip(input logic [3:0] d);
    digit_clip = (d > `FB_DIGIT_MAX) ? `FB_DIGIT_MAX : d;
  endfunction : digit_clip

  // Gives the lamp level for a pattern at a given frame phase.
  function automatic logic lamp_level(input lamp_mode_t m, input logic [`FB_PHASE_W-1:0] ph);
    lamp_level = 1'b0;
    case (m)
      LAMP_ON: lamp_level = 1'b1;
      LAMP_BLINK: lamp_level = ~ph[`FB_BLINK_BIT];
      LAMP_FLASH1: lamp_level = (ph < `FB_FLASH_LEN);
      LAMP_FLASH2: lamp_level = (ph < `FB_FLASH_LEN) || (ph >= `FB_FLASH2_ON && ph < `FB_FLASH2_OFF);
      default: lamp_level = 1'b0;
    endcase
  endfunction : lamp_level

  // ==========================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r, stab_r, stab_nxt;
  assign pins = {SW_TENS, SW_ONES, LINK_ACT_OUT, LINK_UP_OUT, LINK_ACT_IN, LINK_UP_IN};

  // A bit only changes once the second and third stages agree.
  always_comb begin
    stab_nxt = (stab_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
  end

  // Three-stage chain, the first stage feeds only the second.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      {s1_r, s2_r, s3_r, stab_r} <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stab_r <= stab_nxt;
    end
  end

  logic [1:0] link_up, link_act;
  assign link_up = {stab_r[2], stab_r[0]};
  assign link_act = {stab_r[3], stab_r[1]};

  // ==========================================================
  // Lamp timebase
  logic [`FB_TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic [`FB_PHASE_W-1:0] phase_r, phase_nxt;
  logic tick;
  assign tick = (tick_cnt_r == TICK_LAST);

  // Free-running divider and pattern frame phase.
  always_comb begin
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + `FB_TICK_W'(1); // R12
    phase_nxt = tick ? phase_r + `FB_PHASE_W'(1) : phase_r; // R12
  end

  // Registers the timebase.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      {tick_cnt_r, phase_r} <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  // ==========================================================
  // Lamps
  logic [1:0] act_seen_r, act_seen_nxt, act_r, act_nxt, link_led_nxt;
  logic flick_r, flick_nxt, run_nxt, err_nxt;
  lamp_mode_t run_mode, err_mode;

  // Traffic is stretched to a tick so short bursts still flicker the lamp.
  always_comb begin
    act_seen_nxt = link_act | (tick ? 2'b00 : act_seen_r);
    act_nxt = tick ? (act_seen_r | link_act) : act_r;
    flick_nxt = tick ? ~flick_r : flick_r;
    link_led_nxt = link_up & (~act_r | {2{flick_r}}); // R1
    case (slave_state_t'(SLAVE_STATE)) // R2
      ST_INIT: run_mode = LAMP_OFF;
      ST_PREOP: run_mode = LAMP_BLINK;
      ST_SAFEOP: run_mode = LAMP_FLASH1;
      default: run_mode = LAMP_ON;
    endcase
    if (COMM_ERR) begin // R3
      err_mode = LAMP_FLASH2;
    end else if (CFG_ERR) begin
      err_mode = LAMP_BLINK;
    end else begin
      err_mode = LAMP_OFF;
    end
    run_nxt = lamp_level(run_mode, phase_r); // R12
    err_nxt = lamp_level(err_mode, phase_r); // R12
  end

  // Lamp outputs straight from flops.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      {act_seen_r, act_r, flick_r} <= '0;
      {LED_LINK_IN, LED_LINK_OUT, LED_RUN, LED_ERR} <= '0;
    end else begin
      act_seen_r <= act_seen_nxt;
      act_r <= act_nxt;
      flick_r <= flick_nxt;
      LED_LINK_IN <= link_led_nxt[0];
      LED_LINK_OUT <= link_led_nxt[1];
      LED_RUN <= run_nxt;
      LED_ERR <= err_nxt;
    end
  end

  // ==========================================================
  // Station address
  logic [3:0] wait_r, wait_nxt;
  logic [`FB_BCD_W-1:0] sw_addr_r, sw_addr_nxt, sw_calc;
  logic captured_nxt;
  logic [`FB_ADDR_W-1:0] station_nxt;
  assign sw_calc = `FB_BCD_W'(digit_clip(stab_r[11:8])) * `FB_TENS_MUL + `FB_BCD_W'(digit_clip(stab_r[7:4])); // R4

  // Waits for the synchronisers to fill, then latches the switches once.
  always_comb begin
    wait_nxt = wait_r;
    sw_addr_nxt = sw_addr_r;
    captured_nxt = ADDR_CAPTURED;
    if (!ADDR_CAPTURED) begin
      if (wait_r == `FB_CAPTURE_WAIT) begin
        sw_addr_nxt = sw_calc; // R5
        captured_nxt = 1'b1; // R5
      end else begin
        wait_nxt = wait_r + 4'h1;
      end
    end
    station_nxt = ADDR_MODE_FIXED ? `FB_ADDR_W'(sw_addr_r) : ASSIGNED_ADDR; // R6 R7
  end

  // Registers the address state.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      {wait_r, sw_addr_r, ADDR_CAPTURED, STATION_ADDR} <= '0;
    end else begin
      wait_r <= wait_nxt;
      sw_addr_r <= sw_addr_nxt;
      ADDR_CAPTURED <= captured_nxt;
      STATION_ADDR <= station_nxt;
    end
  end

  // ==========================================================
  // Cyclic and acyclic data hand-off
  // Cyclic frames move command and status both ways; parameter writes are their own strobe.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      {DRV_CMD, DRV_TARGET, CYC_STATUS, CYC_ACTUAL} <= '0;
      {CYC_IN_VALID, PARAM_WE, MODBUS_EN} <= '0;
      {PARAM_ADDR, PARAM_WDATA, SLAVE_STATUS} <= '0;
    end else begin
      CYC_IN_VALID <= CYC_OUT_VALID; // R8
      if (CYC_OUT_VALID) begin
        DRV_CMD <= CYC_CMD; // R8
        DRV_TARGET <= CYC_TARGET;
        CYC_STATUS <= DRV_STATUS; // R8
        CYC_ACTUAL <= DRV_ACTUAL;
      end
      PARAM_WE <= PARAM_REQ; // R9
      if (PARAM_REQ) begin
        PARAM_ADDR <= PARAM_INDEX; // R9
        PARAM_WDATA <= PARAM_DATA;
      end
      SLAVE_STATUS <= {COMM_ERR, CFG_ERR, SLAVE_STATE}; // R11
      MODBUS_EN <= 1'b0; // R10
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  property p_link_dark;
    !link_up[0] |=> !LED_LINK_IN;
  endproperty
  a_link_dark: assert property (p_link_dark) else $error("Link lamp lit without link."); // R1
  property p_link_steady;
    link_up[1] && !act_r[1] |=> LED_LINK_OUT;
  endproperty
  a_link_steady: assert property (p_link_steady) else $error("Idle link lamp not steady."); // R1
  property p_run_op;
    (SLAVE_STATE == 2'h3) |=> LED_RUN;
  endproperty
  a_run_op: assert property (p_run_op) else $error("Run lamp dark in operational."); // R2
  property p_run_init;
    (SLAVE_STATE == 2'h0) |=> !LED_RUN;
  endproperty
  a_run_init: assert property (p_run_init) else $error("Run lamp lit in initial state."); // R2
  property p_single_flash;
    (SLAVE_STATE == 2'h2) && (phase_r >= `FB_FLASH_LEN) |=> !LED_RUN;
  endproperty
  a_single_flash: assert property (p_single_flash) else $error("Single flash too long."); // R12
  property p_err_none;
    !CFG_ERR && !COMM_ERR |=> !LED_ERR;
  endproperty
  a_err_none: assert property (p_err_none) else $error("Error lamp lit without error."); // R3
  property p_err_double;
    COMM_ERR && (phase_r == `FB_FLASH2_ON) |=> LED_ERR;
  endproperty
  a_err_double: assert property (p_err_double) else $error("Second flash missing."); // R3
  property p_capture_bound;
    !ADDR_CAPTURED |-> ##[1:12] ADDR_CAPTURED;
  endproperty
  a_capture_bound: assert property (p_capture_bound) else $error("Address never captured."); // R5
  property p_addr_hold;
    ADDR_CAPTURED |=> ADDR_CAPTURED && $stable(sw_addr_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("Captured address changed."); // R5
  property p_fixed;
    ADDR_CAPTURED && ADDR_MODE_FIXED |=> STATION_ADDR == `FB_ADDR_W'($past(sw_addr_r));
  endproperty
  a_fixed: assert property (p_fixed) else $error("Fixed mode ignores switches."); // R6
  property p_assigned;
    !ADDR_MODE_FIXED |=> STATION_ADDR == $past(ASSIGNED_ADDR);
  endproperty
  a_assigned: assert property (p_assigned) else $error("Assigned address not used."); // R7
  property p_cyclic;
    CYC_OUT_VALID |=> CYC_IN_VALID && DRV_CMD == $past(CYC_CMD) && CYC_STATUS == $past(DRV_STATUS);
  endproperty
  a_cyclic: assert property (p_cyclic) else $error("Cyclic exchange lost."); // R8
  property p_param;
    PARAM_REQ |=> PARAM_WE && PARAM_ADDR == $past(PARAM_INDEX) && PARAM_WDATA == $past(PARAM_DATA);
  endproperty
  a_param: assert property (p_param) else $error("Parameter write lost."); // R9
  property p_modbus;
    ADDR_CAPTURED |-> !MODBUS_EN;
  endproperty
  a_modbus: assert property (p_modbus) else $error("Serial path enabled."); // R10
endmodule : fieldbus_slave_status_and_address
`default_nettype wire

/* verification/network_master_model.sv */
// Behavioural network master that sends cyclic frames, parameter writes and address assignments.
`default_nettype none
module network_master_model (
  input wire logic clk,
  output logic fixed_mode,
  output logic [15:0] assigned_addr,
  output logic cyc_valid,
  output logic [15:0] cyc_cmd,
  output logic [15:0] cyc_target,
  output logic param_req,
  output logic [15:0] param_index,
  output logic [15:0] param_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Idle bus at time zero: fixed addressing and no requests.
  initial begin
    {fixed_mode, assigned_addr, cyc_valid, cyc_cmd, cyc_target} = {1'b1, 16'h0000, 1'b0, 32'h0};
    {param_req, param_index, param_data} = 33'h0;
  end
  // ==========================================================
  // Requests start at a falling edge and hold for one cycle; a released bus shows inverted data.
  task automatic set_addressing(input logic f, input logic [15:0] a);
    fixed_mode = f;
    assigned_addr = a;
  endtask : set_addressing
  task automatic cyc_beat(input logic [15:0] c, input logic [15:0] t, input bit last);
    cyc_valid = 1'b1;
    cyc_cmd = c;
    cyc_target = t;
    @(negedge clk);
    if (last) begin
      cyc_valid = 1'b0;
      {cyc_cmd, cyc_target} = ~{c, t};
    end
  endtask : cyc_beat
  task automatic prm_beat(input logic [15:0] i, input logic [15:0] d, input bit last);
    param_req = 1'b1;
    param_index = i;
    param_data = d;
    @(negedge clk);
    if (last) begin
      param_req = 1'b0;
      {param_index, param_data} = ~{i, d};
    end
  endtask : prm_beat
endmodule : network_master_model
`default_nettype wire

/* verification/fieldbus_slave_status_and_address_test.sv */
// Self-checking bench for the fieldbus slave status and address block.
`default_nettype none
module fieldbus_slave_status_and_address_test
  import fb_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, link_up_in, link_act_in, link_up_out, link_act_out, cfg_err, comm_err;
  logic fixed_mode, cyc_valid, param_req, led_link_in, led_link_out, led_run, led_err;
  logic addr_captured, cyc_in_valid, param_we, modbus_en;
  logic [1:0] slave_state;
  logic [3:0] sw_tens, sw_ones, slave_status;
  logic [15:0] assigned_addr, cyc_cmd, cyc_target, drv_status, drv_actual, param_index, param_data;
  logic [15:0] station_addr, drv_cmd, drv_target, cyc_status, cyc_actual, param_addr, param_wdata;
  logic [63:0] cyc_q[$];
  logic [31:0] prm_q[$];
  logic [63:0] e;
  int fails = 0;
  int compares = 0;
  fieldbus_slave_status_and_address #(.TICK_CYCLES(4)) fieldbus_slave_status_and_address_inst (
    .REF_CLK(ref_clk), .RSTN(rstn), .LINK_UP_IN(link_up_in), .LINK_ACT_IN(link_act_in),
    .LINK_UP_OUT(link_up_out), .LINK_ACT_OUT(link_act_out), .SW_TENS(sw_tens), .SW_ONES(sw_ones),
    .SLAVE_STATE(slave_state), .CFG_ERR(cfg_err), .COMM_ERR(comm_err), .ADDR_MODE_FIXED(fixed_mode),
    .ASSIGNED_ADDR(assigned_addr), .CYC_OUT_VALID(cyc_valid), .CYC_CMD(cyc_cmd), .CYC_TARGET(cyc_target),
    .DRV_STATUS(drv_status), .DRV_ACTUAL(drv_actual), .PARAM_REQ(param_req), .PARAM_INDEX(param_index),
    .PARAM_DATA(param_data), .LED_LINK_IN(led_link_in), .LED_LINK_OUT(led_link_out), .LED_RUN(led_run),
    .LED_ERR(led_err), .STATION_ADDR(station_addr), .ADDR_CAPTURED(addr_captured), .DRV_CMD(drv_cmd),
    .DRV_TARGET(drv_target), .CYC_IN_VALID(cyc_in_valid), .CYC_STATUS(cyc_status), .CYC_ACTUAL(cyc_actual),
    .PARAM_WE(param_we), .PARAM_ADDR(param_addr), .PARAM_WDATA(param_wdata), .SLAVE_STATUS(slave_status),
    .MODBUS_EN(modbus_en));
  network_master_model network_master_model_inst (
    .clk(ref_clk), .fixed_mode(fixed_mode), .assigned_addr(assigned_addr), .cyc_valid(cyc_valid),
    .cyc_cmd(cyc_cmd), .cyc_target(cyc_target), .param_req(param_req), .param_index(param_index),
    .param_data(param_data));
  // ==========================================================
  // Clock at 40 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Comparison, verdict and lamp measurement helpers.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic lamp(input logic [7:0] cfg, input int e_in, input int e_out, input int e_run, input int e_err);
    int n[4] = '{0, 0, 0, 0};
    {link_up_in, link_act_in, link_up_out, link_act_out, slave_state, cfg_err, comm_err} = cfg;
    repeat (64) @(negedge ref_clk);
    repeat (128) begin
      @(negedge ref_clk);
      n[0] += int'(led_link_in === 1'b1);
      n[1] += int'(led_link_out === 1'b1);
      n[2] += int'(led_run === 1'b1);
      n[3] += int'(led_err === 1'b1);
    end
    chk("led_link_in", e_in, n[0]);
    chk("led_link_out", e_out, n[1]);
    chk("led_run", e_run, n[2]);
    chk("led_err", e_err, n[3]);
  endtask : lamp
  // ==========================================================
  // Scoreboard: each result pulse takes the oldest note and compares.
  always @(negedge ref_clk) begin
    if (cyc_in_valid === 1'b1) begin
      e = (cyc_q.size() > 0) ? cyc_q.pop_front() : ~{drv_cmd, drv_target, cyc_status, cyc_actual};
      chk("cyclic_result", e[63:32], {drv_cmd, drv_target});
      chk("cyclic_return", e[31:0], {cyc_status, cyc_actual});
    end
    if (param_we === 1'b1) begin
      e = (prm_q.size() > 0) ? {32'h0, prm_q.pop_front()} : {32'h0, ~{param_addr, param_wdata}};
      chk("param_write", e[31:0], {param_addr, param_wdata});
    end
  end
  // ==========================================================
  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
  // ==========================================================
  // Main sequence.
  initial begin
    logic [15:0] c, t, a, exp_addr;
    void'($urandom(32'h8D291594));
    {rstn, link_up_in, link_act_in, link_up_out, link_act_out, cfg_err, comm_err} = 7'h00;
    {slave_state, drv_status, drv_actual} = 34'h0;
    sw_tens = 4'($urandom_range(9));
    sw_ones = 4'($urandom_range(9));
    exp_addr = 16'(sw_tens * 10 + sw_ones);
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    chk("modbus_en", 0, modbus_en);
    chk("station_addr", 0, station_addr);
    for (int i = 0; i < 20 && addr_captured !== 1'b1; i++) @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
    chk("addr_captured", 1, addr_captured);
    chk("station_addr", exp_addr, station_addr);
    sw_tens = 4'(9 - sw_tens);
    sw_ones = 4'(9 - sw_ones);
    repeat (8) @(negedge ref_clk);
    chk("station_addr", exp_addr, station_addr);
    a = 16'($urandom);
    network_master_model_inst.set_addressing(1'b0, a);
    repeat (2) @(negedge ref_clk);
    chk("station_addr", a, station_addr);
    network_master_model_inst.set_addressing(1'b1, a);
    repeat (2) @(negedge ref_clk);
    chk("station_addr", exp_addr, station_addr);
    fork
      for (int i = 0; i < 6; i++) begin
        {c, t, drv_status, drv_actual} = {$urandom, $urandom};
        cyc_q.push_back({c, t, drv_status, drv_actual});
        network_master_model_inst.cyc_beat(c, t, i == 5);
      end
      for (int i = 0; i < 4; i++) begin
        {c, t} = $urandom;
        prm_q.push_back({c, t});
        network_master_model_inst.prm_beat(c, t, i == 3);
      end
    join
    repeat (3) @(negedge ref_clk);
    chk("pending_notes", 0, cyc_q.size() + prm_q.size());
    for (int k = 0; k < 16; k++) begin
      {comm_err, cfg_err, slave_state} = 4'(k);
      @(negedge ref_clk);
      chk("slave_status", k, slave_status);
    end
    lamp({4'b0000, ST_INIT, 2'b00}, 0, 0, 0, 0);
    lamp({4'b1011, ST_PREOP, 2'b10}, 128, 64, 64, 64);
    lamp({4'b1101, ST_SAFEOP, 2'b01}, 64, 0, 16, 32);
    lamp({4'b1010, ST_OP, 2'b11}, 128, 128, 128, 32);
    // A second power-on reset takes the switches again as they now stand.
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    exp_addr = 16'(sw_tens * 10 + sw_ones);
    repeat (14) @(negedge ref_clk);
    chk("addr_captured", 1, addr_captured);
    chk("station_addr", exp_addr, station_addr);
    chk("modbus_en", 0, modbus_en);
    print_verdict();
  end
endmodule : fieldbus_slave_status_and_address_test
`default_nettype wire
